//--- aprt_alert_routing.sv
// Purpose: Routes monitoring events onto the two alert pins
// Assumes: Event inputs come from logic on the same clock; the pin input is asynchronous
// Notes:   Routing registers reached by a simple single-cycle register port
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (RQ1) Bits 6..4 route overpower, channels 2..4
// (RQ2) Bit 3 routes accumulator fullness
// (RQ3) Bit 2 routes sample tally fullness
// (RQ4) First pin bit 1: 5 us conversion pulse
// (RQ5) Conversion pulse only in alert mode
// (RQ6) Alert mode disables low-rate sampling input
// (RQ7) Bit 0 ignores writes, reads zero
// (RQ8) Second routing register at 28H, resets zero
// (RQ9) Second routing only acts in alert mode
// (RQ10) Only globally enabled sources reach pins
// (RQ11) Host disables alerts before changing limits
// (RQ12) Bits 23..20 route overcurrent, channels 1..4
// (RQ13) Bits 19..16 route undercurrent, channels 1..4
// (RQ14) Bit 15 routes channel 1 overvoltage
// (RQ15) Overvoltage, undervoltage bits; second pin pulse
// (RQ16) Pin asserts on OR of routed sources
// (RQ17) First routing register at 27H, same layout
// (RQ18) Bit 7 routes channel 1 overpower
module aprt_alert_routing
	import aprt_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic [APRT_ADDR_W-1:0] reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [APRT_REG_W-1:0]  reg_wdata,
	output logic      [APRT_REG_W-1:0]  reg_rdata,
	input  wire logic [3:0]             overcurrent,
	input  wire logic [3:0]             undercurrent,
	input  wire logic [3:0]             overvoltage,
	input  wire logic [3:0]             undervoltage,
	input  wire logic [3:0]             overpower,
	input  wire logic                   accumulator_full,
	input  wire logic                   sample_tally_full,
	input  wire logic                   conversion_done,
	input  wire logic [APRT_REG_W-1:0]  global_alert_enable,
	input  wire logic                   first_pin_is_alert,
	input  wire logic                   second_pin_is_alert,
	input  wire logic                   first_alert_pin_i,
	output logic                        first_alert_pin_o,
	output logic                        first_alert_pin_oe,
	output logic                        second_alert_pin_o,
	output logic                        second_alert_pin_oe,
	output logic                        slow_sample_req
);

	logic [APRT_REG_W-1:0]  route_r     [APRT_NUM_PINS];
	logic [APRT_REG_W-1:0]  route_nxt   [APRT_NUM_PINS];
	logic [APRT_CNT_W-1:0]  cc_cnt_r    [APRT_NUM_PINS];
	logic [APRT_CNT_W-1:0]  cc_cnt_nxt  [APRT_NUM_PINS];
	logic [APRT_NUM_PINS-1:0] alert_r;
	logic [APRT_NUM_PINS-1:0] alert_nxt;
	logic [APRT_NUM_PINS-1:0] pin_mode;
	logic [APRT_REG_W-1:0]  rdata_nxt;
	logic [APRT_REG_W-1:0]  rdata_r;
	logic                   sync1_r;
	logic                   sync2_r;
	logic                   slow_r;
	logic                   slow_nxt;
	logic [APRT_REG_W-1:0]  src_vec     [APRT_NUM_PINS];

	localparam logic [APRT_CNT_W-1:0] CC_LOAD = APRT_CNT_W'(APRT_CC_PULSE_CYC);
	localparam logic [7:0] ROUTE_ADDR [APRT_NUM_PINS] = '{APRT_FIRST_ROUTE_ADDR,
		APRT_SECOND_ROUTE_ADDR};

	assign pin_mode = {second_pin_is_alert, first_pin_is_alert};

	// Per pin: routing register, conversion pulse timer, alert combine
	for (genvar p = 0; p < APRT_NUM_PINS; p++)
	begin : g_pin
		// Source vector laid out exactly like the routing register
		always_comb
		begin
			src_vec[p]                                  = '0;
			src_vec[p][APRT_OC_LSB +: 4]                = {<<{overcurrent}};  // RQ12
			src_vec[p][APRT_UC_LSB +: 4]                = {<<{undercurrent}}; // RQ13
			src_vec[p][APRT_OV_LSB +: 4]                = {<<{overvoltage}};  // RQ14 RQ15
			src_vec[p][APRT_UV_LSB +: 4]                = {<<{undervoltage}}; // RQ15
			src_vec[p][APRT_OP_LSB +: 4]                = {<<{overpower}};    // RQ1 RQ18
			src_vec[p][APRT_ACC_BIT]                    = accumulator_full;   // RQ2
			src_vec[p][APRT_TALLY_BIT]                  = sample_tally_full;  // RQ3
			src_vec[p][APRT_CC_BIT]                     = (cc_cnt_r[p] != '0); // RQ4 RQ15
		end

		// Next state: register write, pulse timer, gated OR of sources
		always_comb
		begin
			route_nxt[p] = route_r[p];
			if (reg_wr && reg_addr == ROUTE_ADDR[p])
				route_nxt[p] = reg_wdata & APRT_WRITE_MASK; // RQ7 RQ8 RQ17
			cc_cnt_nxt[p] = cc_cnt_r[p];
			// Retrigger restarts the full width so back to back cycles never shorten it
			if (conversion_done && route_r[p][APRT_CC_BIT])
				cc_cnt_nxt[p] = CC_LOAD; // RQ4
			else if (cc_cnt_r[p] != '0)
				cc_cnt_nxt[p] = cc_cnt_r[p] - 1'b1;
			// Only sources enabled both globally and in routing reach the pin
			alert_nxt[p] = pin_mode[p] && |(src_vec[p] & route_r[p] & global_alert_enable); // RQ5 RQ9 RQ10 RQ16
		end

		// Registers
		always_ff @(posedge clock or negedge rstn)
		begin
			if (!rstn)
			begin
				route_r[p]  <= APRT_ROUTE_RESET;
				cc_cnt_r[p] <= '0;
				alert_r[p]  <= 1'b0;
			end
			else
			begin
				route_r[p]  <= route_nxt[p];
				cc_cnt_r[p] <= cc_cnt_nxt[p];
				alert_r[p]  <= alert_nxt[p];
			end
		end
	end

	// Read data and low-rate sampling input
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (reg_rd)
		begin
			if (reg_addr == APRT_FIRST_ROUTE_ADDR)
				rdata_nxt = route_r[0]; // RQ17
			else if (reg_addr == APRT_SECOND_ROUTE_ADDR)
				rdata_nxt = route_r[1]; // RQ8
			else
				rdata_nxt = '0;
		end
		// Pin input is ignored while it serves as an alert output
		slow_nxt = first_pin_is_alert ? 1'b0 : sync2_r; // RQ6
	end

	// Registers: read data, input synchroniser
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata_r <= '0;
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			slow_r  <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			sync1_r <= first_alert_pin_i;
			sync2_r <= sync1_r;
			slow_r  <= slow_nxt;
		end
	end

	assign reg_rdata           = rdata_r;
	assign first_alert_pin_o   = alert_r[0];
	assign second_alert_pin_o  = alert_r[1];
	assign first_alert_pin_oe  = first_pin_is_alert;
	assign second_alert_pin_oe = second_pin_is_alert;
	assign slow_sample_req     = slow_r;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_bit0_reads_zero: assert property (reg_rd |=> reg_rdata[APRT_UNUSED_BIT] == 1'b0) // RQ7
		else $error("routing bit 0 read as one");
	a_second_reg_write: assert property (reg_wr && reg_addr == APRT_SECOND_ROUTE_ADDR // RQ8
		##1 !reg_wr ##1 reg_rd && reg_addr == APRT_SECOND_ROUTE_ADDR && !reg_wr
		|=> reg_rdata == ($past(reg_wdata, 3) & APRT_WRITE_MASK))
		else $error("second routing register did not hold written value");
	a_first_reg_write: assert property (reg_wr && reg_addr == APRT_FIRST_ROUTE_ADDR // RQ17
		##1 !reg_wr ##1 reg_rd && reg_addr == APRT_FIRST_ROUTE_ADDR && !reg_wr
		|=> reg_rdata == ($past(reg_wdata, 3) & APRT_WRITE_MASK))
		else $error("first routing register did not hold written value");
	a_first_pin_mode: assert property (!first_pin_is_alert |=> !first_alert_pin_o) // RQ5
		else $error("first pin alerted outside alert mode");
	a_second_pin_mode: assert property (!second_pin_is_alert |=> !second_alert_pin_o) // RQ9
		else $error("second pin alerted outside alert mode");
	a_global_gate: assert property (global_alert_enable == '0 // RQ10
		|=> !first_alert_pin_o && !second_alert_pin_o)
		else $error("alert reached pin without global enable");
	a_overcurrent_route: assert property (second_pin_is_alert && overcurrent[0] // RQ12
		&& route_r[1][23] && global_alert_enable[23] |=> second_alert_pin_o)
		else $error("channel 1 overcurrent did not reach second pin");
	a_undercurrent_route: assert property (second_pin_is_alert && undercurrent[3] // RQ13
		&& route_r[1][APRT_UC_LSB] && global_alert_enable[APRT_UC_LSB]
		|=> second_alert_pin_o)
		else $error("channel 4 undercurrent did not reach second pin");
	a_overvoltage_route: assert property (first_pin_is_alert && overvoltage[0] // RQ14
		&& route_r[0][15] && global_alert_enable[15] |=> first_alert_pin_o)
		else $error("channel 1 overvoltage did not reach first pin");
	a_overpower_route: assert property (first_pin_is_alert && overpower[1] // RQ1
		&& route_r[0][6] && global_alert_enable[6] |=> first_alert_pin_o)
		else $error("channel 2 overpower did not reach first pin");
	a_acc_route: assert property (first_pin_is_alert && accumulator_full // RQ2
		&& route_r[0][APRT_ACC_BIT] && global_alert_enable[APRT_ACC_BIT]
		|=> first_alert_pin_o)
		else $error("accumulator fullness did not reach first pin");
	a_tally_route: assert property (second_pin_is_alert && sample_tally_full // RQ3
		&& route_r[1][APRT_TALLY_BIT] && global_alert_enable[APRT_TALLY_BIT]
		|=> second_alert_pin_o)
		else $error("sample tally fullness did not reach second pin");
	a_cc_pulse_len: assert property ($rose(cc_cnt_r[0] != '0) // RQ4
		|-> (cc_cnt_r[0] != '0)[*8] ##0 (cc_cnt_r[0] == CC_LOAD - 11'h007))
		else $error("conversion pulse timer misbehaved");
	a_cc_pulse_end: assert property (cc_cnt_r[0] == 11'h001 && !conversion_done // RQ4
		|=> cc_cnt_r[0] == '0)
		else $error("conversion pulse did not end");
	a_second_cc_pulse: assert property (second_pin_is_alert && conversion_done // RQ15
		&& route_r[1][APRT_CC_BIT] ##1 second_pin_is_alert
		&& global_alert_enable[APRT_CC_BIT] |=> second_alert_pin_o)
		else $error("second pin conversion pulse missing");
	a_slow_blocked: assert property (first_pin_is_alert |=> !slow_sample_req) // RQ6
		else $error("low-rate input active in alert mode");

endmodule : aprt_alert_routing // aprt_alert_routing

`default_nettype wire

//--- aprt_pkg.sv
// Purpose: Constants for the alert pin source routing block
// Assumes: 250 MHz clock, 24-bit routing registers
// Notes:   Bit layout is shared by both routing registers and the enable mask
package aprt_pkg;
	localparam int          APRT_REG_W        = 24;
	localparam int          APRT_ADDR_W       = 8;
	localparam int          APRT_NUM_PINS     = 2;
	// Register offsets
	localparam logic [7:0]  APRT_FIRST_ROUTE_ADDR  = 8'h27;
	localparam logic [7:0]  APRT_SECOND_ROUTE_ADDR = 8'h28;
	localparam logic [23:0] APRT_ROUTE_RESET       = 24'h000000;
	// Field positions
	localparam int          APRT_OC_LSB       = 20;
	localparam int          APRT_UC_LSB       = 16;
	localparam int          APRT_OV_LSB       = 12;
	localparam int          APRT_UV_LSB       = 8;
	localparam int          APRT_OP_LSB       = 4;
	localparam int          APRT_ACC_BIT      = 3;
	localparam int          APRT_TALLY_BIT    = 2;
	localparam int          APRT_CC_BIT       = 1;
	localparam int          APRT_UNUSED_BIT   = 0;
	// Writable bits: bit 0 is unimplemented
	localparam logic [23:0] APRT_WRITE_MASK   = 24'hFFFFFE;
	// Timing
	localparam int          APRT_CLK_PERIOD_PS = 4000;
	// Conversion pulse width, 5 us, held in ns
	localparam int          APRT_CC_PULSE_NS   = 5000;
	// Multiply before dividing so integer division cannot cut it to 1000 cycles
	localparam int          APRT_CC_PULSE_CYC  = (APRT_CC_PULSE_NS * 1000) / APRT_CLK_PERIOD_PS;
	localparam int          APRT_CNT_W         = 11;
endpackage : aprt_pkg

//--- aprt_host_watch.sv
// Purpose: Host side watcher of the first alert pin
// Assumes: Pin level sampled on the device clock
// Notes:   Latches the length of the last high run
`timescale 1ns/1ps
`default_nettype none
module aprt_host_watch
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        pin,
	output logic      [15:0] last_len
);
	logic [15:0] run_r;
	// Count high cycles, keep the run length at the fall
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			run_r    <= 16'h0000;
			last_len <= 16'h0000;
		end
		else
		begin
			run_r <= pin ? run_r + 16'h0001 : 16'h0000;
			if (!pin && run_r != 16'h0000)
				last_len <= run_r;
		end
	end
endmodule // aprt_host_watch
`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the alert routing block
// Assumes: Strobe register port, one clock
// Notes:   Sources driven as one vector in routing bit layout
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import aprt_pkg::*;
	logic        clock, rstn, reg_wr, reg_rd, cd, sel1, sel2, slow_in;
	logic [7:0]  reg_addr;
	logic [23:0] reg_wdata, reg_rdata, src, ena, d;
	logic [3:0]  oc, uc, ov, uv, op;
	logic        p1o, p1oe, p2o, p2oe, slow_req, pin1_i;
	logic [15:0] len;
	int          num_errors, comparisons, cyc;
	// Bit 23 is channel 1 while input bit 0 is channel 1
	for (genvar i = 0; i < 4; i++)
	begin : g_map
		assign oc[i] = src[23-i];
		assign uc[i] = src[19-i];
		assign ov[i] = src[15-i];
		assign uv[i] = src[11-i];
		assign op[i] = src[7-i];
	end
	// Pin level: own driver wins, else the outside source
	assign pin1_i = p1oe ? p1o : slow_in;
	aprt_alert_routing dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .overcurrent(oc),
		.undercurrent(uc), .overvoltage(ov), .undervoltage(uv), .overpower(op),
		.accumulator_full(src[3]), .sample_tally_full(src[2]), .conversion_done(cd),
		.global_alert_enable(ena), .first_pin_is_alert(sel1), .second_pin_is_alert(sel2),
		.first_alert_pin_i(pin1_i), .first_alert_pin_o(p1o), .first_alert_pin_oe(p1oe),
		.second_alert_pin_o(p2o), .second_alert_pin_oe(p2oe), .slow_sample_req(slow_req));
	aprt_host_watch host (.clock(clock), .rstn(rstn), .pin(p1o), .last_len(len));
	task check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [23:0] v);
		@(posedge clock);
		reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [23:0] v);
		@(posedge clock);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task t_regs;
		rd(8'h27, d);
		check(d, 24'h000000);
		rd(8'h28, d);
		check(d, 24'h000000);
		wr(8'h28, 24'hFFFFFF);
		rd(8'h28, d);
		check(d, 24'hFFFFFE);
		wr(8'h27, 24'hAAAAAB);
		rd(8'h27, d);
		check(d, 24'hAAAAAA);
		// Unmapped write must leave both registers alone
		wr(8'h30, 24'h000000);
		rd(8'h28, d);
		check(d, 24'hFFFFFE);
		rd(8'h27, d);
		check(d, 24'hAAAAAA);
		rd(8'h30, d);
		check(d, 24'h000000);
	endtask
	// Walk every level source onto each pin alone; the other register is cleared
	task t_route;
		for (int p = 0; p < 2; p++)
			for (int b = 2; b < 24; b++)
			begin
				@(posedge clock);
				ena <= 24'h0;
				src <= 24'h0;
				wr(8'h27, p ? 24'h0 : 24'h1 << b);
				wr(8'h28, p ? 24'h1 << b : 24'h0);
				@(posedge clock);
				ena <= 24'h1 << b;
				src <= 24'h1 << b;
				wait_cyc(2);
				check({22'h0, p2o, p1o}, 24'(p + 1));
				@(posedge clock);
				ena <= 24'h0;
				wait_cyc(2);
				check({22'h0, p2o, p1o}, 24'h0);
			end
		wr(8'h27, 24'h0);
	endtask
	task t_mode;
		@(posedge clock);
		sel2 <= 1'b0;
		ena <= 24'h800000;
		src <= 24'h800000;
		wait_cyc(3);
		check({22'h0, p2oe, p2o}, 24'h0);
		@(posedge clock);
		sel1 <= 1'b0;
		slow_in <= 1'b1;
		src <= 24'h0;
		wait_cyc(4);
		check({22'h0, p1oe, slow_req}, 24'h1);
		// Pin driven high from inside, so a leak would show on the request
		@(posedge clock);
		sel1 <= 1'b1;
		sel2 <= 1'b1;
		src <= 24'h800000;
		wr(8'h27, 24'h800000);
		wait_cyc(4);
		check({21'h0, p1oe, p1o, slow_req}, 24'h6);
	endtask
	task t_pulse;
		wr(8'h27, 24'h000002);
		@(posedge clock);
		ena <= 24'h000002;
		src <= 24'h0;
		cd <= 1'b1;
		@(posedge clock);
		cd <= 1'b0;
		wait_cyc(1300);
		check({8'h0, len}, 24'h0004E2);
		@(posedge clock);
		sel1 <= 1'b0;
		cd <= 1'b1;
		@(posedge clock);
		cd <= 1'b0;
		wait_cyc(8);
		check({23'h0, p1o}, 24'h0);
		// Second pin pulse from its own bit 1, which must also end
		wr(8'h28, 24'h000002);
		@(posedge clock);
		cd <= 1'b1;
		@(posedge clock);
		cd <= 1'b0;
		wait_cyc(3);
		check({23'h0, p2o}, 24'h1);
		wait_cyc(1260);
		check({23'h0, p2o}, 24'h0);
	endtask
	task results;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Clock, and a hang guard well beyond the expected run
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			results();
		end
	end
	initial
	begin
		{rstn, reg_wr, reg_rd, cd, slow_in, reg_addr, reg_wdata, src, ena} = '0;
		{sel1, sel2} = 2'b11;
		num_errors = 0; comparisons = 0; cyc = 0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_regs(); t_route(); t_mode(); t_pulse();
		results();
	end
endmodule // testbench
`default_nettype wire
